//--- verilog/usb_port_map.svh
`ifndef USB_PORT_MAP_SVH
`define USB_PORT_MAP_SVH
`define OFS_HOST_VERSION   12'h400
`define OFS_HOST_CONTROL   12'h404
`define OFS_PORT_STATUS    12'h450
`define VERSION_BCD        8'h10
`define PS_CONNECT         0
`define PS_CONNECT_CHG     1
`define PS_ENABLE          2
`define PS_ENABLE_CHG      3
`define PS_OVC_ACTIVE      4
`define PS_OVC_CHG         5
`define PS_RESUME          6
`define HC_RATIO_LO        0
`define HC_PERIODIC_EN     2
`define HC_ISO_EN          3
`define HC_CONTROL_EN      4
`define HC_BULK_EN         5
`define HC_STATE_LO        6
`define HC_ROUTING         8
`define HC_WAKE_CONN       9
`define HC_WAKE_EN         10
`define HC_WRITE_MASK      32'h0000_07FF
`define RESUME_EXIT_US     2000
`define SOF_DELAY_US       1000
`define CLK_MHZ            250
`endif

//--- verilog/usb_port_pkg.sv
`default_nettype none
package usb_port_pkg;
  typedef enum logic [1:0] {
    state_reset       = 2'b00,
    state_resume      = 2'b01,
    state_operational = 2'b10,
    state_suspend     = 2'b11
  } func_state_e;
  typedef enum logic [1:0] {
    list_periodic,
    list_control,
    list_bulk,
    list_idle
  } list_sel_e;
endpackage : usb_port_pkg
`default_nettype wire

//--- verilog/usb_port_ctrl.sv
// Notes on behaviour
// - J-to-K while suspended sets resume bit and port change detect pulse.
// - Software setting resume bit raises no port change detect.
// - K driven while resume set; after clear, idle reached within 2 ms. The code stops K a cycle after the zero write; the bit clears at idle or after 2 ms.
// - Over-current change set on any over-current edge; write one clears.
// - Over-current active bit mirrors the present over-current condition.
// - Enable change set only on disable for port error at EOF2.
// - Writing one to enable ignored; set only when reset finds high-speed.
// - Disconnect, fault or software zero disables; disabled port blocks data.
// - Connect change set on every connect edge, even already set.
// - Connect status bit shows present attach state.
// - Port power off forces resume, enable, enable change, connect change and connect to zero.
// - Port status resets only on hardware or controller reset.
// - Version field is read-only 0x10.
// - Wake enable with resume detected raises remote wakeup, not interrupt.
// - Wake connected cleared by hardware reset, kept over software reset.
// - Routing bit steers interrupts to normal or management line.
// - State codes 00,01,10,11; soft reset suspends, hard reset resets.
// - Entering operational starts start-of-frame tokens 1 ms later.
// - Hardware changes state only from suspend to resume on resume.
// - List enables take effect at next frame start.
// - Isochronous descriptor with iso disabled ends periodic, goes to lists.
// - Ratio N serves N+1 control per bulk; count kept across frames.
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "usb_port_map.svh"
module usb_port_ctrl #(
  parameter int unsigned RESUME_EXIT_CYC = (`RESUME_EXIT_US * `CLK_MHZ),
  parameter int unsigned SOF_DELAY_CYC   = (`SOF_DELAY_US * `CLK_MHZ)
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_soft_rst,
  input  wire logic [11:0]       wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic              wb_we_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              i_port_power,
  input  wire logic              i_line_k,
  input  wire logic              i_connect,
  input  wire logic              i_overcurrent,
  input  wire logic              i_port_error_eof2,
  input  wire logic              i_reset_done_hs,
  input  wire logic              i_hs_idle,
  input  wire logic              i_frame_start,
  input  wire logic              i_iso_desc_seen,
  input  wire logic              i_ctrl_desc_done,
  input  wire logic              i_bulk_desc_done,
  input  wire logic              i_irq_event,
  output logic                   o_port_change_detect,
  output logic                   o_drive_resume_k,
  output logic                   o_port_data_block,
  output logic                   o_sof_enable,
  output logic                   o_remote_wakeup,
  output logic                   o_irq_host,
  output logic                   o_irq_smi,
  output logic                   o_downstream_reset,
  output usb_port_pkg::func_state_e o_func_state,
  output usb_port_pkg::list_sel_e   o_list_sel
);
  import usb_port_pkg::*;

  localparam int unsigned RW = 22;

  // Two-stage synchronisers for the port pins.
  logic [4:0] pin_meta_reg;
  logic [4:0] pin_sync_reg;
  logic       k_prev_reg;
  logic       conn_prev_reg;
  logic       ovc_prev_reg;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_meta_reg  <= '0;
      pin_sync_reg  <= '0;
      k_prev_reg    <= 1'b0;
      conn_prev_reg <= 1'b0;
      ovc_prev_reg  <= 1'b0;
    end else begin
      pin_meta_reg  <= {i_port_power, i_line_k, i_connect, i_overcurrent, i_hs_idle};
      pin_sync_reg  <= pin_meta_reg;
      k_prev_reg    <= pin_sync_reg[3];
      conn_prev_reg <= pin_sync_reg[2];
      ovc_prev_reg  <= pin_sync_reg[1];
    end
  end
  logic pwr;
  logic k_line;
  logic conn;
  logic ovc;
  logic hs_idle;
  assign {pwr, k_line, conn, ovc, hs_idle} = pin_sync_reg;

  // Wishbone classic slave: one-cycle ack, dropped after one cycle.
  logic bus_req;
  logic wr_en;
  logic wr_port;
  logic wr_ctrl;
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en   = bus_req && wb_we_i;
  assign wr_port = wr_en && (wb_adr_i == `OFS_PORT_STATUS) && wb_sel_i[0];
  assign wr_ctrl = wr_en && (wb_adr_i == `OFS_HOST_CONTROL);

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  // Port status bits.
  logic resume_reg;
  logic enable_reg;
  logic en_chg_reg;
  logic conn_chg_reg;
  logic ovc_chg_reg;
  logic [RW-1:0] exit_cnt_reg;
  logic resume_exit_reg;
  logic j_to_k;
  assign j_to_k = k_line && !k_prev_reg && resume_reg == 1'b0 && enable_reg
                  && o_func_state == state_suspend;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      resume_reg      <= 1'b0;
      resume_exit_reg <= 1'b0;
      exit_cnt_reg    <= '0;
    end else if (i_soft_rst || !pwr) begin
      resume_reg      <= 1'b0;
      resume_exit_reg <= 1'b0;
      exit_cnt_reg    <= '0;
    end else if (j_to_k) begin
      resume_reg <= 1'b1;
    end else if (wr_port && wb_dat_i[`PS_RESUME] && !resume_reg) begin
      resume_reg <= 1'b1;
    end else if (wr_port && !wb_dat_i[`PS_RESUME] && resume_reg && !resume_exit_reg) begin
      resume_exit_reg <= 1'b1;
      exit_cnt_reg    <= '0;
    end else if (resume_exit_reg) begin
      exit_cnt_reg <= exit_cnt_reg + 1'b1;
      if (hs_idle || exit_cnt_reg >= RW'(RESUME_EXIT_CYC - 1)) begin
        resume_reg      <= 1'b0;
        resume_exit_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_port_change_detect <= 1'b0;
      o_drive_resume_k     <= 1'b0;
      o_port_data_block    <= 1'b1;
    end else begin
      o_port_change_detect <= j_to_k && pwr && !i_soft_rst;
      o_drive_resume_k     <= resume_reg && !resume_exit_reg;
      o_port_data_block    <= !enable_reg;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      enable_reg <= 1'b0;
      en_chg_reg <= 1'b0;
    end else if (i_soft_rst || !pwr) begin
      enable_reg <= 1'b0;
      en_chg_reg <= 1'b0;
    end else begin
      if (!conn || i_port_error_eof2 || (wr_port && !wb_dat_i[`PS_ENABLE])) begin
        enable_reg <= 1'b0;
      end else if (i_reset_done_hs) begin
        enable_reg <= 1'b1;
      end
      if (i_port_error_eof2 && enable_reg) begin
        en_chg_reg <= 1'b1;
      end else if (wr_port && wb_dat_i[`PS_ENABLE_CHG]) begin
        en_chg_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      conn_chg_reg <= 1'b0;
      ovc_chg_reg  <= 1'b0;
    end else if (i_soft_rst) begin
      conn_chg_reg <= 1'b0;
      ovc_chg_reg  <= 1'b0;
    end else begin
      if (pwr && conn != conn_prev_reg) begin
        conn_chg_reg <= 1'b1;
      end else if (!pwr || (wr_port && wb_dat_i[`PS_CONNECT_CHG])) begin
        conn_chg_reg <= 1'b0;
      end
      if (ovc != ovc_prev_reg) begin
        ovc_chg_reg <= 1'b1;
      end else if (wr_port && wb_dat_i[`PS_OVC_CHG]) begin
        ovc_chg_reg <= 1'b0;
      end
    end
  end

  logic [31:0] port_rd;
  always_comb begin
    port_rd = '0;
    port_rd[`PS_CONNECT]     = conn && pwr;
    port_rd[`PS_CONNECT_CHG] = conn_chg_reg;
    port_rd[`PS_ENABLE]      = enable_reg;
    port_rd[`PS_ENABLE_CHG]  = en_chg_reg;
    port_rd[`PS_OVC_ACTIVE]  = ovc;
    port_rd[`PS_OVC_CHG]     = ovc_chg_reg;
    port_rd[`PS_RESUME]      = resume_reg;
  end

  // Host control register.
  logic [10:0] ctrl_reg;
  logic [10:0] ctrl_next;
  logic [31:0] ctrl_merged;
  assign ctrl_merged = lane_merge({21'h0, ctrl_reg}, wb_dat_i, wb_sel_i)
                       & `HC_WRITE_MASK;
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = ctrl_merged[10:0];
    end else if (ctrl_reg[`HC_STATE_LO +: 2] == state_suspend && j_to_k) begin
      ctrl_next[`HC_STATE_LO +: 2] = state_resume;
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_reg <= '0;
    end else if (i_soft_rst) begin
      ctrl_reg <= {ctrl_reg[10:8], state_suspend, 6'h00};
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Start-of-frame delay after entering operational.
  logic [RW-1:0] sof_cnt_reg;
  logic          sof_wait_reg;
  logic          entering_op;
  assign entering_op = ctrl_next[`HC_STATE_LO +: 2] == state_operational
                       && ctrl_reg[`HC_STATE_LO +: 2] != state_operational;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sof_cnt_reg  <= '0;
      sof_wait_reg <= 1'b0;
      o_sof_enable <= 1'b0;
    end else if (i_soft_rst || ctrl_next[`HC_STATE_LO +: 2] != state_operational) begin
      sof_cnt_reg  <= '0;
      sof_wait_reg <= 1'b0;
      o_sof_enable <= 1'b0;
    end else if (entering_op) begin
      sof_cnt_reg  <= '0;
      sof_wait_reg <= 1'b1;
    end else if (sof_wait_reg) begin
      sof_cnt_reg <= sof_cnt_reg + 1'b1;
      if (sof_cnt_reg >= RW'(SOF_DELAY_CYC - 1)) begin
        sof_wait_reg <= 1'b0;
        o_sof_enable <= 1'b1;
      end
    end
  end

  // List enables latched at frame start; list selection with ratio count.
  logic [3:0] list_en_reg;
  logic [1:0] ratio_cnt_reg;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      list_en_reg <= '0;
    end else if (i_frame_start) begin
      list_en_reg <= ctrl_reg[5:2];
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_list_sel    <= list_idle;
      ratio_cnt_reg <= '0;
    end else begin
      if (i_frame_start) begin
        o_list_sel <= ctrl_reg[`HC_PERIODIC_EN] ? list_periodic : list_control;
      end else if (o_list_sel == list_periodic && i_iso_desc_seen && !list_en_reg[1]) begin
        o_list_sel <= list_control;
      end else if (i_ctrl_desc_done) begin
        if (ratio_cnt_reg >= ctrl_reg[1:0] && list_en_reg[3]) begin
          ratio_cnt_reg <= '0;
          o_list_sel    <= list_bulk;
        end else begin
          ratio_cnt_reg <= ratio_cnt_reg + 1'b1;
        end
      end else if (i_bulk_desc_done) begin
        o_list_sel <= list_en_reg[2] ? list_control : list_bulk;
      end
    end
  end

  // Remote wakeup, interrupt routing and state output.
  logic resume_seen_reg;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      resume_seen_reg    <= 1'b0;
      o_remote_wakeup    <= 1'b0;
      o_irq_host         <= 1'b0;
      o_irq_smi          <= 1'b0;
      o_downstream_reset <= 1'b1;
      o_func_state       <= state_reset;
    end else begin
      if (j_to_k) begin
        resume_seen_reg <= 1'b1;
      end else if (i_soft_rst || !ctrl_reg[`HC_WAKE_EN]) begin
        resume_seen_reg <= 1'b0;
      end
      o_remote_wakeup    <= ctrl_reg[`HC_WAKE_EN] && resume_seen_reg;
      o_irq_host         <= i_irq_event && !ctrl_reg[`HC_ROUTING];
      o_irq_smi          <= i_irq_event && ctrl_reg[`HC_ROUTING];
      o_downstream_reset <= ctrl_reg[`HC_STATE_LO +: 2] == state_reset;
      o_func_state       <= func_state_e'(ctrl_reg[`HC_STATE_LO +: 2]);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= '0;
      if (bus_req && !wb_we_i) begin
        unique case (wb_adr_i)
          `OFS_HOST_VERSION: wb_dat_o <= {24'h0, `VERSION_BCD};
          `OFS_HOST_CONTROL: wb_dat_o <= {21'h0, ctrl_reg};
          `OFS_PORT_STATUS:  wb_dat_o <= port_rd;
          default:           wb_dat_o <= '0;
        endcase
      end
    end
  end

  a_ovc_change: assert property (@(posedge i_clk) disable iff (i_rst)
    (ovc != ovc_prev_reg && !i_soft_rst) |=> ovc_chg_reg)
    else $error("over-current change not flagged");
  a_enable_ignore: assert property (@(posedge i_clk) disable iff (i_rst)
    (!enable_reg && !i_reset_done_hs) |=> !enable_reg)
    else $error("enable set without high-speed reset");
  a_conn_change: assert property (@(posedge i_clk) disable iff (i_rst)
    (pwr && conn != conn_prev_reg && !i_soft_rst) |=> conn_chg_reg)
    else $error("connect change lost");
  a_power_off: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(pwr) |=> (!resume_reg && !enable_reg && !en_chg_reg))
    else $error("fields not cleared on power off");
  a_resume_pcd: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_port && !j_to_k) |=> !o_port_change_detect)
    else $error("change detect on software resume");
  // Independent count of the cycles spent returning to high-speed idle.
  logic [RW-1:0] exit_watch_reg;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      exit_watch_reg <= '0;
    end else if (resume_exit_reg) begin
      exit_watch_reg <= exit_watch_reg + 1'b1;
    end else begin
      exit_watch_reg <= '0;
    end
  end
  a_resume_exit: assert property (@(posedge i_clk) disable iff (i_rst)
    resume_exit_reg |-> exit_watch_reg < RW'(RESUME_EXIT_CYC))
    else $error("resume exit exceeded 2 ms");
  a_version_ro: assert property (@(posedge i_clk) disable iff (i_rst)
    (bus_req && !wb_we_i && wb_adr_i == `OFS_HOST_VERSION) |=> wb_dat_o == 32'h0000_0010)
    else $error("version read wrong");
  a_routing_split: assert property (@(posedge i_clk) disable iff (i_rst)
    i_irq_event |=> (o_irq_smi == ctrl_reg[`HC_ROUTING] || $past(wr_ctrl)))
    else $error("interrupt misrouted");
  c_j_to_k: cover property (@(posedge i_clk) disable iff (i_rst) j_to_k);
  c_sof_on: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_sof_enable));
  c_bulk: cover property (@(posedge i_clk) disable iff (i_rst) o_list_sel == list_bulk);
endmodule : usb_port_ctrl
`default_nettype wire

//--- testbench/usb_device_model.sv
`timescale 1ns/1ps
`default_nettype none
module usb_device_model (
  input  wire logic       i_clk,
  input  wire logic       i_attach,
  input  wire logic       i_wake,
  input  wire logic       i_fault,
  input  wire logic       i_drive_k,
  input  wire logic [7:0] i_idle_delay,
  output logic            o_connect,
  output logic            o_line_k,
  output logic            o_overcurrent,
  output logic            o_hs_idle
);
  logic [7:0] idle_cnt = 8'h00;
  assign o_connect     = i_attach;
  assign o_overcurrent = i_fault;
  // The line shows K whether the device or the host drives it.
  assign o_line_k      = i_attach & (i_wake | i_drive_k);
  initial o_hs_idle = 1'b1;
  // High-speed idle comes back a chosen number of cycles after the host stops K.
  always @(posedge i_clk) begin
    if (i_drive_k) begin
      idle_cnt  <= i_idle_delay;
      o_hs_idle <= 1'b0;
    end else if (idle_cnt != 8'h00) begin
      idle_cnt <= idle_cnt - 8'h01;
    end else begin
      o_hs_idle <= 1'b1;
    end
  end
endmodule : usb_device_model
`default_nettype wire

//--- testbench/test_usb_port_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "usb_port_map.svh"
module test_usb_port_ctrl;
  import usb_port_pkg::*;
  localparam int          SOFC = 20;
  localparam logic [11:0] PS   = `OFS_PORT_STATUS;
  localparam logic [11:0] HC   = `OFS_HOST_CONTROL;
  localparam logic [11:0] HV   = `OFS_HOST_VERSION;
  logic        i_clk = 0, i_rst = 1, i_soft_rst = 0, we = 0, cyc = 0, stb = 0;
  logic [11:0] adr = '0;
  logic [3:0]  sel = 4'hF;
  logic [31:0] wdat = '0, q, wb_dat_o;
  logic        pwr = 0, attach = 0, wake = 0, fault = 0, wb_ack_o, seen;
  logic [6:0]  ev = '0;
  logic [7:0]  idle_dly = 8'h1e;
  logic        chg, drive_k, blk, sof, rwake, irq_h, irq_s, dsr, line_k, conn, ovc, hs_idle;
  func_state_e st;
  list_sel_e   ls;
  int          fails = 0, samples_checked = 0, n;

  usb_port_ctrl #(.RESUME_EXIT_CYC(20), .SOF_DELAY_CYC(SOFC)) DUT (
    .i_clk(i_clk), .i_rst(i_rst), .i_soft_rst(i_soft_rst), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .i_port_power(pwr), .i_line_k(line_k), .i_connect(conn),
    .i_overcurrent(ovc), .i_port_error_eof2(ev[0]), .i_reset_done_hs(ev[1]),
    .i_hs_idle(hs_idle), .i_frame_start(ev[2]), .i_iso_desc_seen(ev[3]),
    .i_ctrl_desc_done(ev[4]), .i_bulk_desc_done(ev[5]), .i_irq_event(ev[6]),
    .o_port_change_detect(chg), .o_drive_resume_k(drive_k), .o_port_data_block(blk),
    .o_sof_enable(sof), .o_remote_wakeup(rwake), .o_irq_host(irq_h), .o_irq_smi(irq_s),
    .o_downstream_reset(dsr), .o_func_state(st), .o_list_sel(ls));

  usb_device_model dev (.i_clk(i_clk), .i_attach(attach), .i_wake(wake), .i_fault(fault),
    .i_drive_k(drive_k), .i_idle_delay(idle_dly), .o_connect(conn), .o_line_k(line_k),
    .o_overcurrent(ovc), .o_hs_idle(hs_idle));

  always #2 i_clk = ~i_clk;

  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic ticks(input int k);
    repeat (k) @(posedge i_clk);
  endtask : ticks

  task automatic expire(input logic hit);
    if (hit) begin
      fails++;
      conclude();
    end
  endtask : expire

  task automatic acc(input logic [11:0] a, input logic w, input logic [31:0] d);
    int t;
    t = 0;
    adr <= a;
    we <= w;
    wdat <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    do begin
      @(posedge i_clk);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 40);
    expire(wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge i_clk);
  endtask : acc

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    acc(a, 1'b0, 32'h0000_0000);
    chk(nm, q, e);
  endtask : rdc

  task automatic rps(input string nm, input logic [31:0] e);
    acc(PS, 1'b0, 32'h0000_0000);
    chk(nm, q & 32'h0000_007F, e);
  endtask : rps

  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge i_clk);
    ev[k] <= 1'b0;
    @(posedge i_clk);
  endtask : pulse

  initial begin
    ticks(16);
    i_rst <= 1'b0;
    ticks(1);
    rdc("version", HV, 32'h0000_0010);
    acc(HV, 1'b1, 32'h0000_0000);
    rdc("version kept", HV, 32'h0000_0010);
    rdc("control reset", HC, 32'h0000_0000);
    chk("state reset", 32'(st), 32'(state_reset));
    rps("port reset", 32'h0000_0000);
    rdc("unmapped", 12'h7FC, 32'h0000_0000);
    $display("test reset done");
    pwr <= 1'b1;
    attach <= 1'b1;
    ticks(6);
    rps("attach", 32'h0000_0003);
    acc(PS, 1'b1, 32'h0000_0002);
    attach <= 1'b0;
    ticks(6);
    attach <= 1'b1;
    ticks(6);
    rps("reattach", 32'h0000_0003);
    sel <= 4'hE;
    acc(PS, 1'b1, 32'h0000_0002);
    sel <= 4'hF;
    rps("lane ignored", 32'h0000_0003);
    acc(PS, 1'b1, 32'h0000_0006);
    rps("enable by write", 32'h0000_0001);
    chk("blocked", 32'(blk), 1);
    pulse(1);
    rps("hs enable", 32'h0000_0005);
    chk("unblocked", 32'(blk), 0);
    pulse(0);
    rps("eof2 error", 32'h0000_0009);
    acc(PS, 1'b1, 32'h0000_0008);
    pulse(1);
    acc(PS, 1'b1, 32'h0000_0000);
    rps("sw disable", 32'h0000_0001);
    pulse(1);
    attach <= 1'b0;
    ticks(6);
    rps("disconnect", 32'h0000_0002);
    fault <= 1'b1;
    ticks(6);
    rps("ovc on", 32'h0000_0032);
    acc(PS, 1'b1, 32'h0000_0022);
    fault <= 1'b0;
    ticks(6);
    rps("ovc off", 32'h0000_0020);
    acc(PS, 1'b1, 32'h0000_0020);
    attach <= 1'b1;
    ticks(6);
    pulse(1);
    pwr <= 1'b0;
    ticks(6);
    rps("power off", 32'h0000_0000);
    pwr <= 1'b1;
    ticks(6);
    $display("test port done");
    acc(HC, 1'b1, 32'hFFFF_FFFF);
    rdc("control mask", HC, 32'h0000_07FF);
    acc(HC, 1'b1, 32'h0000_0100);
    pulse(6);
    chk("route smi", 32'({irq_s, irq_h}), 2);
    acc(HC, 1'b1, 32'h0000_0000);
    pulse(6);
    chk("route host", 32'({irq_s, irq_h}), 1);
    acc(HC, 1'b1, 32'h0000_0080);
    n = 0;
    while (sof !== 1'b1 && n < 100) begin
      @(posedge i_clk);
      n++;
    end
    chk("sof delay", n, SOFC - 1);
    expire(sof !== 1'b1);
    for (int r = 0; r < 4; r++) begin
      acc(HC, 1'b1, 32'h0000_00B0 | r);
      pulse(2);
      n = 0;
      while (ls !== list_bulk && n < 8) begin
        pulse(4);
        n++;
      end
      chk("ratio", n, r + 1);
      expire(ls !== list_bulk);
      pulse(5);
    end
    acc(HC, 1'b1, 32'h0000_0084);
    pulse(2);
    pulse(2);
    chk("periodic", 32'(ls), 32'(list_periodic));
    pulse(3);
    chk("iso stop", 32'(ls), 32'(list_control));
    $display("test control done");
    pulse(1);
    acc(HC, 1'b1, 32'h0000_04C0);
    wake <= 1'b1;
    seen = 1'b0;
    repeat (10) begin
      @(posedge i_clk);
      seen = seen | chg;
    end
    wake <= 1'b0;
    chk("change detect", 32'(seen), 1);
    rps("resume hw", 32'h0000_0045);
    chk("state resume", 32'(st), 32'(state_resume));
    chk("wakeup", 32'(rwake), 1);
    chk("drive k", 32'(drive_k), 1);
    acc(PS, 1'b1, 32'h0000_0000);
    rps("resume held", 32'h0000_0041);
    ticks(40);
    rps("resume done", 32'h0000_0001);
    idle_dly <= 8'h02;
    acc(PS, 1'b1, 32'h0000_0040);
    seen = 1'b0;
    repeat (10) begin
      @(posedge i_clk);
      seen = seen | chg;
    end
    chk("sw resume", 32'(seen), 0);
    chk("sw drive k", 32'(drive_k), 1);
    acc(PS, 1'b1, 32'h0000_0000);
    ticks(12);
    rps("fast idle", 32'h0000_0001);
    $display("test resume done");
    acc(HC, 1'b1, 32'h0000_0795);
    i_soft_rst <= 1'b1;
    ticks(2);
    i_soft_rst <= 1'b0;
    ticks(2);
    rdc("soft reset", HC, 32'h0000_07C0);
    rps("soft port", 32'h0000_0001);
    i_rst <= 1'b1;
    ticks(2);
    chk("downstream reset", 32'(dsr), 1);
    i_rst <= 1'b0;
    ticks(2);
    rdc("hard reset", HC, 32'h0000_0000);
    $display("test resets done");
    conclude();
  end
endmodule : test_usb_port_ctrl
`default_nettype wire
